/* File: hdl/lsp_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module lsp_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pads and filtered levels
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a new level only once two stages agree, acting as a glitch filter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_o <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_o[i] <= s3_q[i];
				end
			end
		end
	end

endmodule : lsp_pin_sync
`default_nettype wire

/* File: hdl/lsp_pkg.sv */
`default_nettype none

package lsp_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] P4_DATA_IDX = 10'h008;
	localparam logic [IDX_W-1:0] P5_DATA_IDX = 10'h009;
	localparam logic [IDX_W-1:0] P4_DIR_IDX = 10'h088;
	localparam logic [IDX_W-1:0] P5_DIR_IDX = 10'h089;
	localparam logic [IDX_W-1:0] P6_DATA_IDX = 10'h107;
	localparam logic [IDX_W-1:0] SEG_EN_IDX = 10'h10D;
	localparam logic [IDX_W-1:0] P6_DIR_IDX = 10'h187;

	// Reset values
	localparam logic [7:0] P4_DATA_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [7:0] SEG_EN_RST = 8'hFF;

	// Segment enable field positions
	localparam int SE_P4_LO = 0;
	localparam int SE_P5_LO_A = 1;
	localparam int SE_P5_LO_B = 2;
	localparam int SE_P6_LO = 3;
	localparam int SE_P6_HI = 4;
	localparam int SE_OTHER = 5;
	localparam int SE_P5_HI = 6;
	localparam int SE_P4_HI = 7;

	// Segment numbering of the shared pins
	localparam int SEG_P4_BASE = 0;
	localparam int SEG_P4_HI_BASE = 24;
	localparam int SEG_P5_BASE = 5;
	localparam int SEG_P5_TOP = 27;
	localparam int SEG_P6_BASE = 12;
	localparam int P4_IO_PINS = 5;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// One pin group as driven towards the pads
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe_n;
	} lsp_pad_t;

	// Drive levels offered by the LCD waveform generator
	typedef struct packed {
		logic [31:0] seg;
		logic [3:1] com;
		logic [3:1] com_use;
	} lsp_lcd_src_t;

endpackage : lsp_pkg
`default_nettype wire

/* File: hdl/lsp_port_pins.sv */
// Overview of operation
// - Port four: eight Schmitt inputs, pins 0-4 bidirectional digital or segment drivers.
// - Port four pins 5-7: digital input or LCD driver, never digital output.
// - Port four direction acts only on pins 0-4 and only in digital mode.
// - After reset every shared pin is an LCD segment or common driver.
// - A set segment enable forces LCD drive regardless of direction bits.
// - Port four pins 0-4 carry segments 0-4 in LCD mode.
// - Port four pins 5-7 carry segments 29-31 or commons 3, 2, 1.
// - Port five: eight input-only Schmitt pins, each shared with a segment.
// - Port five pins 0-6 carry segments 5-11; pin 7 carries segment 27.
// - Port five pin 7 and segment 27 are absent on the reduced package.
// - Port six: eight input-only Schmitt pins, each shared with a segment.
// - Port six pins 0-7 carry segments 12-19 in LCD mode.
// - Data reads return pin levels; port four data writes load the output latch, port five and six data writes are dropped.
// - Port four direction set means high impedance; clear drives the latch onto the pin. Port five and six direction bits are stored but drive nothing.
`timescale 1ns/1ps
`default_nettype none

module lsp_port_pins #(
	parameter bit FULL_PACKAGE = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [lsp_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [lsp_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// LCD waveform levels
	input wire lsp_pkg::lsp_lcd_src_t lcd_src,
	// Pads
	input wire logic [7:0] p4_pad_i,
	input wire logic [7:0] p5_pad_i,
	input wire logic [7:0] p6_pad_i,
	output lsp_pkg::lsp_pad_t p4_pad,
	output lsp_pkg::lsp_pad_t p5_pad,
	output lsp_pkg::lsp_pad_t p6_pad
);

	logic [7:0] p4_latch_q;
	logic [7:0] dir4_q;
	logic [7:0] dir5_q;
	logic [7:0] dir6_q;
	logic [7:0] seg_en_q;
	logic [7:0] p4_lvl;
	logic [7:0] p5_lvl;
	logic [7:0] p6_lvl;
	logic [7:0] p5_rd;
	logic acc_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [lsp_pkg::IDX_W-1:0] w_idx;
	logic [lsp_pkg::IDX_W-1:0] r_idx;
	logic w_hit;
	logic r_hit;
	logic wr_en;
	logic [7:0] rd_byte;
	logic [7:0] p4_o_d;
	logic [7:0] p4_oe_n_d;
	logic [7:0] p5_o_d;
	logic [7:0] p5_oe_n_d;
	logic [7:0] p6_o_d;
	logic [7:0] p6_oe_n_d;

	// Input conditioning
	// Schmitt port inputs
	lsp_pin_sync #(.WIDTH(8)) u_sync4 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_i(p4_pad_i),
		.level_o(p4_lvl)
	);
	lsp_pin_sync #(.WIDTH(8)) u_sync5 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_i(p5_pad_i),
		.level_o(p5_lvl)
	);
	lsp_pin_sync #(.WIDTH(8)) u_sync6 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_i(p6_pad_i),
		.level_o(p6_lvl)
	);

	assign p5_rd = FULL_PACKAGE ? p5_lvl : {1'b0, p5_lvl[6:0]};

	// Write path: address and data are taken together in one cycle
	assign w_idx = awaddr[lsp_pkg::ADDR_W-1:2];
	assign r_idx = araddr[lsp_pkg::ADDR_W-1:2];
	assign w_hit = (w_idx == lsp_pkg::P4_DATA_IDX) || (w_idx == lsp_pkg::P5_DATA_IDX) ||
		(w_idx == lsp_pkg::P6_DATA_IDX) || (w_idx == lsp_pkg::P4_DIR_IDX) ||
		(w_idx == lsp_pkg::P5_DIR_IDX) || (w_idx == lsp_pkg::P6_DIR_IDX) ||
		(w_idx == lsp_pkg::SEG_EN_IDX);
	assign r_hit = (r_idx == lsp_pkg::P4_DATA_IDX) || (r_idx == lsp_pkg::P5_DATA_IDX) ||
		(r_idx == lsp_pkg::P6_DATA_IDX) || (r_idx == lsp_pkg::P4_DIR_IDX) ||
		(r_idx == lsp_pkg::P5_DIR_IDX) || (r_idx == lsp_pkg::P6_DIR_IDX) ||
		(r_idx == lsp_pkg::SEG_EN_IDX);
	assign wr_en = acc_q && wstrb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= 1'b0;
		end else begin
			acc_q <= awvalid && wvalid && !acc_q && !bvalid_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= lsp_pkg::RESP_OKAY;
		end else if (acc_q) begin
			bvalid_q <= 1'b1;
			bresp_q <= w_hit ? lsp_pkg::RESP_OKAY : lsp_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p4_latch_q <= lsp_pkg::P4_DATA_RST;
		end else if (wr_en && w_idx == lsp_pkg::P4_DATA_IDX) begin
			p4_latch_q <= wdata[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir4_q <= lsp_pkg::DIR_RST;
			dir5_q <= lsp_pkg::DIR_RST;
			dir6_q <= lsp_pkg::DIR_RST;
		end else if (wr_en) begin
			if (w_idx == lsp_pkg::P4_DIR_IDX) begin
				dir4_q <= wdata[7:0];
			end
			if (w_idx == lsp_pkg::P5_DIR_IDX) begin
				dir5_q <= wdata[7:0];
			end
			if (w_idx == lsp_pkg::P6_DIR_IDX) begin
				dir6_q <= wdata[7:0];
			end
		end
	end

	// All groups start as LCD drivers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_en_q <= lsp_pkg::SEG_EN_RST;
		end else if (wr_en && w_idx == lsp_pkg::SEG_EN_IDX) begin
			seg_en_q <= wdata[7:0];
		end
	end

	// Read path
	always_comb begin
		rd_byte = 8'h00;
		unique case (r_idx)
			lsp_pkg::P4_DATA_IDX: rd_byte = p4_lvl;
			lsp_pkg::P5_DATA_IDX: rd_byte = p5_rd;
			lsp_pkg::P6_DATA_IDX: rd_byte = p6_lvl;
			lsp_pkg::P4_DIR_IDX: rd_byte = dir4_q;
			lsp_pkg::P5_DIR_IDX: rd_byte = dir5_q;
			lsp_pkg::P6_DIR_IDX: rd_byte = dir6_q;
			lsp_pkg::SEG_EN_IDX: rd_byte = seg_en_q;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
		end else begin
			arready_q <= arvalid && !arready_q && !rvalid_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= lsp_pkg::RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (arready_q) begin
			rvalid_q <= 1'b1;
			rresp_q <= r_hit ? lsp_pkg::RESP_OKAY : lsp_pkg::RESP_SLVERR;
			rdata_q <= {24'h00_0000, rd_byte};
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Pad steering, one slice per pin
	for (genvar i = 0; i < 8; i++) begin : g_pin
		if (i < lsp_pkg::P4_IO_PINS) begin : g_p4_io
			// Direction honoured in digital mode only
			assign p4_o_d[i] = seg_en_q[lsp_pkg::SE_P4_LO] ?
				lcd_src.seg[lsp_pkg::SEG_P4_BASE + i] : p4_latch_q[i];
			assign p4_oe_n_d[i] = seg_en_q[lsp_pkg::SE_P4_LO] ? 1'b0 : dir4_q[i];
		end else begin : g_p4_in
			// Upper pins: LCD drive or input only
			assign p4_o_d[i] = lcd_src.com_use[8 - i] ?
				lcd_src.com[8 - i] : lcd_src.seg[lsp_pkg::SEG_P4_HI_BASE + i];
			assign p4_oe_n_d[i] = !seg_en_q[lsp_pkg::SE_P4_HI];
		end
		if (i < 4) begin : g_p5_a
			assign p5_o_d[i] = lcd_src.seg[lsp_pkg::SEG_P5_BASE + i];
			assign p5_oe_n_d[i] = !seg_en_q[lsp_pkg::SE_P5_LO_A];
		end else if (i < 7) begin : g_p5_b
			assign p5_o_d[i] = lcd_src.seg[lsp_pkg::SEG_P5_BASE + i];
			assign p5_oe_n_d[i] = !seg_en_q[lsp_pkg::SE_P5_LO_B];
		end else begin : g_p5_top
			// Segment 27, absent on the reduced package
			assign p5_o_d[i] = FULL_PACKAGE && lcd_src.seg[lsp_pkg::SEG_P5_TOP];
			assign p5_oe_n_d[i] = !(FULL_PACKAGE && seg_en_q[lsp_pkg::SE_P5_HI]);
		end
		// Segments 12-19, driver off in digital mode
		assign p6_o_d[i] = lcd_src.seg[lsp_pkg::SEG_P6_BASE + i];
		assign p6_oe_n_d[i] = (i < 4) ? !seg_en_q[lsp_pkg::SE_P6_LO] :
			!seg_en_q[lsp_pkg::SE_P6_HI];
	end

	// Pads registered so they never glitch through the mux
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p4_pad <= '{o: 8'h00, oe_n: 8'h00};
			p5_pad <= '{o: 8'h00, oe_n: FULL_PACKAGE ? 8'h00 : 8'h80};
			p6_pad <= '{o: 8'h00, oe_n: 8'h00};
		end else begin
			p4_pad <= '{o: p4_o_d, oe_n: p4_oe_n_d};
			p5_pad <= '{o: p5_o_d, oe_n: p5_oe_n_d};
			p6_pad <= '{o: p6_o_d, oe_n: p6_oe_n_d};
		end
	end

	assign awready = acc_q;
	assign wready = acc_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

	// Release edge still launches reset pads, so checking starts one edge later
	logic live_q;
	always_ff @(posedge aclk) begin
		live_q <= aresetn;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !live_q);

	AST_POR_LCD: assert property ($rose(aresetn) |-> p4_pad.oe_n[4:0] == 5'h00 && seg_en_q == 8'hFF)
		else $error("pins not in LCD mode after reset");
	AST_SE_OVERRIDE: assert property (seg_en_q[0] |=> p4_pad.oe_n[4:0] == 5'h00)
		else $error("segment enable did not override direction");
	AST_DIR_DIGITAL: assert property (!seg_en_q[0] && !dir4_q[2] |=> !p4_pad.oe_n[2] && p4_pad.o[2] == $past(p4_latch_q[2]))
		else $error("digital output does not show latch");
	AST_DIR_HIZ: assert property (!seg_en_q[0] && dir4_q[3] |=> p4_pad.oe_n[3])
		else $error("direction set but driver on");
	AST_UPPER_NO_OUT: assert property (!seg_en_q[7] |=> p4_pad.oe_n[7:5] == 3'b111)
		else $error("upper port four pin driven in digital mode");
	AST_COM_MAP: assert property (seg_en_q[7] && lcd_src.com_use[3] |=> p4_pad.o[5] == $past(lcd_src.com[3]))
		else $error("common three not on pin five");
	AST_P5_MAP: assert property (seg_en_q[2] |=> p5_pad.o[6] == $past(lcd_src.seg[11]) && !p5_pad.oe_n[6])
		else $error("port five segment mapping wrong");
	AST_P6_INPUT: assert property (!seg_en_q[4] |=> p6_pad.oe_n[7:4] == 4'hF)
		else $error("input-only pin driven");
	AST_P6_MAP: assert property (seg_en_q[3] |=> p6_pad.o[0] == $past(lcd_src.seg[12]))
		else $error("port six segment mapping wrong");
	AST_READ_PIN: assert property (arready_q && r_idx == lsp_pkg::P6_DATA_IDX |=> rvalid && rdata[7:0] == $past(p6_lvl))
		else $error("data read did not return pin level");
	AST_WRITE_LATCH: assert property (acc_q && wstrb[0] && w_idx == lsp_pkg::P4_DATA_IDX |=> p4_latch_q == $past(wdata[7:0]) ##0 bvalid)
		else $error("write did not load latch");
	AST_REDUCED: assert property (!FULL_PACKAGE |-> p5_pad.oe_n[7] && p5_rd[7] == 1'b0)
		else $error("absent pin is active");

	COV_WRITE: cover property (acc_q ##1 bvalid && bready);
	COV_READ: cover property (arready_q ##1 rvalid && rready);
	COV_DIGITAL_OUT: cover property (!seg_en_q[0] && dir4_q[4:0] == 5'h00);
	COV_UNMAPPED: cover property (bvalid && bresp == lsp_pkg::RESP_SLVERR);

endmodule : lsp_port_pins
`default_nettype wire

/* File: test/lcd_shared_port_pins_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module lcd_shared_port_pins_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = '0;
	logic awvalid = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [11:0] araddr = '0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	lsp_pkg::lsp_lcd_src_t lcd = '0;
	lsp_pkg::lsp_pad_t p4_pad, p5_pad, p6_pad;
	lsp_pkg::lsp_pad_t p5_pad_r;
	logic [7:0] p4_pad_i, p5_pad_i, p6_pad_i;
	logic [23:0] ext = '0;
	int n_fail = 0;
	int n_compared = 0;
	logic [7:0] mv [7];
	logic [7:0] lvl [3];
	logic [11:0] ra [7];

	lsp_port_pins DUT (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .lcd_src(lcd), .p4_pad_i, .p5_pad_i, .p6_pad_i,
		.p4_pad, .p5_pad, .p6_pad
	);

	// Reduced package twin on the same bus; only its port five pads are watched
	lsp_port_pins #(.FULL_PACKAGE(1'b0)) dut_reduced (
		.aclk, .aresetn, .awaddr, .awvalid, .awready(), .wdata, .wstrb, .wvalid,
		.wready(), .bresp(), .bvalid(), .bready, .araddr, .arvalid, .arready(), .rdata(),
		.rresp(), .rvalid(), .rready, .lcd_src(lcd), .p4_pad_i, .p5_pad_i, .p6_pad_i,
		.p4_pad(), .p5_pad(p5_pad_r), .p6_pad()
	);

	lsp_far_side far (.p4_pad, .p5_pad, .p6_pad, .ext, .p4_pad_i, .p5_pad_i, .p6_pad_i);

	initial begin
		forever #10 aclk = ~aclk;
	end

	task automatic report_and_stop();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic axw(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		// Upper lanes carry noise; only bits 7:0 may matter
		wdata <= {24'($urandom), v};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		r = bresp;
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : axr

	task automatic wr(input int k, input logic [7:0] v);
		logic [3:0] s;
		logic [1:0] r;
		s = 4'($urandom);
		axw(ra[k], v, s, r);
		chk("write resp", 32'(r), 32'(lsp_pkg::RESP_OKAY));
		if (s[0] && k != 1 && k != 4) begin
			mv[k] = v;
		end
	endtask : wr

	task automatic chk_pads();
		logic [7:0] z [3];
		logic [7:0] o [3];
		int g;
		int sg;
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 8; i++) begin
				g = (p == 0) ? ((i < 5) ? 0 : 7) :
					(p == 1) ? ((i < 4) ? 1 : (i < 7) ? 2 : 6) : ((i < 4) ? 3 : 4);
				sg = (p == 0) ? ((i < 5) ? i : 24 + i) : (p == 1) ? ((i < 7) ? 5 + i : 27) : 12 + i;
				z[p][i] = mv[5][g] ? 1'b0 : (p == 0 && i < 5) ? mv[2][i] : 1'b1;
				o[p][i] = (p == 0 && i > 4 && lcd.com_use[8 - i]) ? lcd.com[8 - i] : lcd.seg[sg];
				if (!mv[5][g] && p == 0) begin
					o[p][i] = mv[0][i];
				end
				lvl[p][i] = z[p][i] ? ext[8 * p + i] : o[p][i];
				o[p][i] = o[p][i] & ~z[p][i];
			end
		end
		chk("p4 oe_n", 32'(p4_pad.oe_n), 32'(z[0]));
		chk("p4 o", 32'(p4_pad.o & ~p4_pad.oe_n), 32'(o[0]));
		chk("p5 oe_n", 32'(p5_pad.oe_n), 32'(z[1]));
		chk("p5 o", 32'(p5_pad.o & ~p5_pad.oe_n), 32'(o[1]));
		chk("p6 oe_n", 32'(p6_pad.oe_n), 32'(z[2]));
		chk("p6 o", 32'(p6_pad.o & ~p6_pad.oe_n), 32'(o[2]));
		chk("p5 oe_n reduced", 32'(p5_pad_r.oe_n), 32'(z[1] | 8'h80));
		chk("p5 o reduced", 32'(p5_pad_r.o & ~p5_pad_r.oe_n), 32'(o[1] & 8'h7F));
	endtask : chk_pads

	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] eb;
		void'($urandom(32'hFF4DCB4D));
		ra = '{12'h020, 12'h024, 12'h220, 12'h224, 12'h41C, 12'h434, 12'h61C};
		mv = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
		lcd.seg <= $urandom;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int t = 0; t < 8; t++) begin
			if (t > 0) begin
				lcd.seg <= $urandom;
				lcd.com <= 3'($urandom);
				lcd.com_use <= 3'($urandom);
				ext <= 24'($urandom);
				if (t == 4) begin
					// Mid-run reset must bring back the power-on state
					aresetn <= 1'b0;
					repeat (4) @(posedge aclk);
					aresetn <= 1'b1;
					mv = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
				end else begin
					wr(5, 8'($urandom));
					for (int k = 0; k < 7; k++) begin
						if (k != 5) wr(k, 8'($urandom));
					end
				end
			end
			if (t == 1) begin
				axw(12'hFFC, 8'h00, 4'hF, r);
				chk("unmapped bresp", 32'(r), 32'(lsp_pkg::RESP_SLVERR));
				axr(12'h004, d, r);
				chk("unmapped rresp", 32'(r), 32'(lsp_pkg::RESP_SLVERR));
				chk("unmapped rdata", d, 32'h00000000);
			end
			repeat (8) @(posedge aclk);
			// Passes zero and four check the reset state
			chk_pads();
			for (int k = 0; k < 7; k++) begin
				axr(ra[k], d, r);
				chk("read resp", 32'(r), 32'(lsp_pkg::RESP_OKAY));
				eb = (k == 0) ? lvl[0] : (k == 1) ? lvl[1] : (k == 4) ? lvl[2] : mv[k];
				chk("read data", d, {24'h000000, eb});
			end
			$display("test %0d done", t);
		end
		report_and_stop();
	end
endmodule : lcd_shared_port_pins_tb

`default_nettype wire

/* File: test/lsp_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

module lsp_far_side (
	// Pads as driven by the block
	input wire lsp_pkg::lsp_pad_t p4_pad,
	input wire lsp_pkg::lsp_pad_t p5_pad,
	input wire lsp_pkg::lsp_pad_t p6_pad,
	// Levels offered by outside digital sources
	input wire logic [23:0] ext,
	// Resolved pad levels
	output logic [7:0] p4_pad_i,
	output logic [7:0] p5_pad_i,
	output logic [7:0] p6_pad_i
);
	// Glass is passive; an outside source shows only where the block lets go
	assign p4_pad_i = (p4_pad.oe_n & ext[7:0]) | (~p4_pad.oe_n & p4_pad.o);
	assign p5_pad_i = (p5_pad.oe_n & ext[15:8]) | (~p5_pad.oe_n & p5_pad.o);
	assign p6_pad_i = (p6_pad.oe_n & ext[23:16]) | (~p6_pad.oe_n & p6_pad.o);
endmodule : lsp_far_side

`default_nettype wire
